// ### shared/tifs_pkg.sv
package tifs_pkg;

  // Register word indices (byte address is four times the index)
  localparam logic [7:0] IDX_PT_EVENT = 8'h1d;
  localparam logic [7:0] IDX_FIFO_LO = 8'h1e;
  localparam logic [7:0] IDX_FIFO_HI = 8'h1f;
  localparam logic [7:0] IDX_PT_MASK = 8'h1c;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h24;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h25;
  localparam int ADDR_W = 10;

  // Event bit positions
  localparam int EV_FIELD_ON_WAIT = 7;
  localparam int EV_SLOT_LEVEL = 6;
  localparam int EV_FIELD_ON = 5;
  localparam int EV_AUTO_RESP = 4;
  localparam int EV_TYPE_F_ACTIVE = 3;
  localparam int EV_A_STAR = 1;
  localparam int EV_A_ACTIVE = 0;
  localparam logic [7:0] EV_USED = 8'hfb;

  // Status register 2 layout
  localparam int FH_UNDERFLOW = 5;
  localparam int FH_OVERFLOW = 4;
  localparam int FH_LB_LSB = 1;
  localparam int FH_NO_PARITY = 0;

  // Local interrupt status bits
  localparam int IS_PT_EVENT = 0;
  localparam int IS_UNDERFLOW = 1;
  localparam int IS_OVERFLOW = 2;

  localparam int FIFO_DEPTH = 512;
  localparam int SLOT_WATER = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_IRQ = 3'h0;

  typedef struct packed {
    logic field_on_wait;
    logic field_on;
    logic auto_resp;
    logic type_f_active;
    logic a_star;
    logic a_active;
  } tifs_events_t;

  typedef struct packed {
    logic [9:0] level;
    logic rd_empty;
    logic wr_full;
    logic rx_done;
    logic [2:0] last_byte_bits;
    logic missing_parity_flag;
  } tifs_fifo_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } tifs_av_req_t;

endpackage

// ### verilog/tifs_status.sv
`timescale 1ns/10ps
module tifs_status #(
  parameter int DEPTH = tifs_pkg::FIFO_DEPTH,
  parameter int SLOT_WATER = tifs_pkg::SLOT_WATER
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire tifs_pkg::tifs_av_req_t av_req,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  output logic av_response_err,
  // Event sources
  input wire tifs_pkg::tifs_events_t ev_in,
  input wire logic [3:0] time_slot_free,
  input wire logic slot_update,
  input wire logic passive_mode,
  // FIFO side
  input wire tifs_pkg::tifs_fifo_t fifo_in,
  // Interrupt
  output logic irq
);

  logic [7:0] pt_flags_ff;
  logic [7:0] pt_mask_ff;
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_mask_ff;
  logic unf_ff;
  logic ovr_ff;
  logic [2:0] lb_ff;
  logic np_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic err_ff;
  logic slot_hit_ff;
  logic [7:0] set_ev;
  logic req;
  logic take;
  logic rd_events;
  logic rd_fifo_hi;
  logic [7:0] fifo_hi;
  localparam int ADDRW = tifs_pkg::ADDR_W - 2;
  logic [ADDRW-1:0] idx;

  assign req = av_req.read | av_req.write;
  // One wait cycle, then the access completes
  assign av_waitrequest = req & ~ack_ff;
  assign take = req & ack_ff;
  assign idx = av_req.address[tifs_pkg::ADDR_W-1:2];
  assign rd_events = take & av_req.read &
                     (idx == ADDRW'(tifs_pkg::IDX_PT_EVENT));
  assign rd_fifo_hi = take & av_req.read &
                      (idx == ADDRW'(tifs_pkg::IDX_FIFO_HI));
  assign av_readdata = rdata_ff;
  assign av_response_err = err_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // Slot water level: pulse on reaching exactly the threshold
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slot_hit_ff <= 1'b0;
    end else if (slot_update) begin
      slot_hit_ff <= (time_slot_free == 4'(SLOT_WATER));
    end
  end

  always_comb begin
    set_ev = 8'h00;
    set_ev[tifs_pkg::EV_FIELD_ON_WAIT] = ev_in.field_on_wait;
    set_ev[tifs_pkg::EV_SLOT_LEVEL] = slot_update & ~slot_hit_ff &
      (time_slot_free == 4'(SLOT_WATER));
    set_ev[tifs_pkg::EV_FIELD_ON] = ev_in.field_on;
    set_ev[tifs_pkg::EV_AUTO_RESP] = passive_mode & ev_in.auto_resp;
    set_ev[tifs_pkg::EV_TYPE_F_ACTIVE] = ev_in.type_f_active;
    set_ev[tifs_pkg::EV_A_STAR] = ev_in.a_star;
    set_ev[tifs_pkg::EV_A_ACTIVE] = ev_in.a_active;
  end

  // Clear on read only what was captured; later events survive
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pt_flags_ff <= tifs_pkg::RST_BYTE;
    end else if (rd_events) begin
      pt_flags_ff <= (pt_flags_ff & ~rdata_ff[7:0]) | set_ev;
    end else begin
      pt_flags_ff <= pt_flags_ff | set_ev;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      unf_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end else begin
      // Only a flag already captured in read data is cleared
      unf_ff <= (unf_ff &
        ~(rd_fifo_hi & rdata_ff[tifs_pkg::FH_UNDERFLOW])) |
        fifo_in.rd_empty;
      ovr_ff <= (ovr_ff &
        ~(rd_fifo_hi & rdata_ff[tifs_pkg::FH_OVERFLOW])) |
        fifo_in.wr_full;
    end
  end

  // Last byte info latched at end of reception
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lb_ff <= 3'h0;
      np_ff <= 1'b0;
    end else if (fifo_in.rx_done) begin
      lb_ff <= fifo_in.last_byte_bits;
      np_ff <= fifo_in.missing_parity_flag;
    end
  end

  always_comb begin
    fifo_hi = tifs_pkg::RST_BYTE;
    fifo_hi[7:6] = fifo_in.level[9:8];
    fifo_hi[tifs_pkg::FH_UNDERFLOW] = unf_ff;
    fifo_hi[tifs_pkg::FH_OVERFLOW] = ovr_ff;
    fifo_hi[tifs_pkg::FH_LB_LSB+:3] = lb_ff;
    fifo_hi[tifs_pkg::FH_NO_PARITY] = np_ff;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pt_mask_ff <= tifs_pkg::RST_BYTE;
      irq_mask_ff <= tifs_pkg::RST_IRQ;
    end else if (take & av_req.write) begin
      if (idx == ADDRW'(tifs_pkg::IDX_PT_MASK)) begin
        pt_mask_ff <= av_req.writedata[7:0] & tifs_pkg::EV_USED;
      end
      if (idx == ADDRW'(tifs_pkg::IDX_IRQ_MASK)) begin
        irq_mask_ff <= av_req.writedata[2:0];
      end
    end
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_ff <= tifs_pkg::RST_IRQ;
    end else begin
      irq_stat_ff <= (irq_stat_ff &
        ~((take & av_req.write &
           (idx == ADDRW'(tifs_pkg::IDX_IRQ_STAT))) ?
          av_req.writedata[2:0] : 3'h0)) |
        {fifo_in.wr_full, fifo_in.rd_empty,
         |(set_ev & ~pt_mask_ff)};
    end
  end

  // Event source also drives irq while pending and unmasked
  assign irq = |(irq_stat_ff & ~irq_mask_ff) |
               |(pt_flags_ff & ~pt_mask_ff);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
    end else if (req & ~ack_ff) begin
      rdata_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
      unique case (idx)
        ADDRW'(tifs_pkg::IDX_PT_EVENT): rdata_ff[7:0] <= pt_flags_ff;
        ADDRW'(tifs_pkg::IDX_FIFO_LO): rdata_ff[7:0] <= fifo_in.level[7:0];
        ADDRW'(tifs_pkg::IDX_FIFO_HI): rdata_ff[7:0] <= fifo_hi;
        ADDRW'(tifs_pkg::IDX_PT_MASK): rdata_ff[7:0] <= pt_mask_ff;
        ADDRW'(tifs_pkg::IDX_IRQ_STAT): rdata_ff[2:0] <= irq_stat_ff;
        ADDRW'(tifs_pkg::IDX_IRQ_MASK): rdata_ff[2:0] <= irq_mask_ff;
        default: err_ff <= 1'b1;
      endcase
    end
  end

endmodule

// ### verification/tifs_status_chk.sv
`timescale 1ns/10ps
module tifs_status_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register bus
  input wire tifs_pkg::tifs_av_req_t av_req,
  input wire logic [31:0] av_readdata,
  input wire logic av_waitrequest,
  input wire logic av_response_err,
  // Sources and interrupt
  input wire tifs_pkg::tifs_events_t ev_in,
  input wire logic slot_update,
  input wire tifs_pkg::tifs_fifo_t fifo_in,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic req = av_req.read | av_req.write;
  wire logic acc = av_req.read & !av_waitrequest;
  wire logic [7:0] ix = av_req.address[9:2];
  wire logic src = (|ev_in) | slot_update | fifo_in.rd_empty |
    fifo_in.wr_full | av_req.write;
  property p_wait; $rose(req) |-> av_waitrequest ##1 !av_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");
  property p_idle; !req |-> !av_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("wait while idle");
  property p_lo; acc && ix == 8'h1e && $stable(fifo_in.level) |->
    av_readdata == {24'h0, fifo_in.level[7:0]}; endproperty
  a_lo: assert property (p_lo) else $error("low count wrong");
  property p_hi; acc && ix == 8'h1f && $stable(fifo_in.level) |->
    av_readdata[31:6] == {24'h0, fifo_in.level[9:8]}; endproperty
  a_hi: assert property (p_hi) else $error("high count wrong");
  property p_err; acc && !(ix inside {8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h24,
    8'h25}) |-> av_response_err && av_readdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped read wrong");
  property p_unf; acc && ix == 8'h1f && $past(fifo_in.rd_empty, 3) |->
    av_readdata[5]; endproperty
  a_unf: assert property (p_unf) else $error("underflow lost");
  property p_ovr; acc && ix == 8'h1f && $past(fifo_in.wr_full, 3) |->
    av_readdata[4]; endproperty
  a_ovr: assert property (p_ovr) else $error("overflow lost");
  property p_src; $rose(irq) |-> $past(src) || $past(src, 2); endproperty
  a_src: assert property (p_src) else $error("irq without cause");
endmodule
bind tifs_status tifs_status_chk tifs_status_chk_i (.clk, .arst_n, .av_req,
  .av_readdata, .av_waitrequest, .av_response_err, .ev_in, .slot_update,
  .fifo_in, .irq);

// ### verification/tifs_host.sv
`timescale 1ns/10ps
module tifs_host (
  // Clock
  input wire logic clk,
  // Register bus
  output tifs_pkg::tifs_av_req_t av_req,
  input wire logic [31:0] av_readdata,
  input wire logic av_waitrequest,
  input wire logic av_response_err,
  // Receiver status
  input wire logic hard_framing_error
);
  initial av_req = '0;
  task automatic acc(input logic wr, input logic [7:0] ix, wd,
    output logic [7:0] rd, output logic er);
    @(posedge clk);
    av_req <= '{address: {ix, 2'h0}, read: !wr, write: wr,
      writedata: {24'h0, wd}};
    do @(posedge clk); while (av_waitrequest !== 1'b0);
    rd = av_readdata[7:0];
    er = av_response_err;
    if (!wr && ix == 8'h1f && hard_framing_error) rd[3:0] = 4'h0;
    av_req <= '0;
  endtask
endmodule

// ### verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk, arst_n, slot_update, passive_mode, hfe, er, irq;
  logic [3:0] time_slot_free;
  tifs_pkg::tifs_events_t ev_in;
  tifs_pkg::tifs_fifo_t fifo_in;
  tifs_pkg::tifs_av_req_t av_req;
  logic [31:0] av_readdata;
  logic av_waitrequest, av_response_err;
  logic [7:0] rd;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  // Passive, slot update, free slots, events, expected flags
  localparam logic [19:0] ROWS [9] = '{20'h82080, 20'h81020, 20'h80810,
    20'h00800, 20'h80408, 20'h80202, 20'h80101, 20'hd4000, 20'hd0040};
  tifs_status tifs_status_i (.clk, .arst_n, .av_req, .av_readdata,
    .av_waitrequest, .av_response_err, .ev_in, .time_slot_free,
    .slot_update, .passive_mode, .fifo_in, .irq);
  tifs_host tifs_host_i (.clk, .av_req, .av_readdata, .av_waitrequest,
    .av_response_err, .hard_framing_error(hfe));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [7:0] g, e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rdc(input logic [7:0] ix, e);
    tifs_host_i.acc(1'b0, ix, 8'h00, rd, er);
    chk(rd, e);
  endtask
  task wr(input logic [7:0] ix, d);
    tifs_host_i.acc(1'b1, ix, d, rd, er);
  endtask
  task irqc(input logic e);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h0, irq}, {7'h0, e});
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    {arst_n, slot_update, hfe, time_slot_free, ev_in, fifo_in} = '0;
    passive_mode = 1;
    repeat (16) @(posedge clk);
    chk({7'h0, irq} | av_readdata[7:0], 8'h00);
    arst_n <= 1;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      {passive_mode, slot_update, time_slot_free, ev_in} <= ROWS[i][19:8];
      @(posedge clk);
      {slot_update, ev_in} <= '0;
      irqc(ROWS[i][7:0] != 8'h00);
      rdc(8'h1d, ROWS[i][7:0]);
      rdc(8'h1d, 8'h00);
      wr(8'h24, 8'h07);
    end
    @(posedge clk);
    fifo_in <= {10'h1ab, 3'h1, 3'h5, 1'b1};
    @(posedge clk);
    fifo_in.rx_done <= 1'b0;
    rdc(8'h1e, 8'hab);
    rdc(8'h1f, 8'h4b);
    hfe <= 1'b1;
    rdc(8'h1f, 8'h40);
    hfe <= 1'b0;
    fifo_in <= {10'h200, 3'h6, 3'h5, 1'b1};
    @(posedge clk);
    fifo_in[6:4] <= 3'h0;
    rdc(8'h1f, 8'hbb);
    rdc(8'h1e, 8'h00);
    rdc(8'h1f, 8'h8b);
    irqc(1'b1);
    wr(8'h24, 8'h07);
    wr(8'h1c, 8'h01);
    rdc(8'h1c, 8'h01);
    ev_in.a_active <= 1'b1;
    @(posedge clk);
    ev_in.a_active <= 1'b0;
    irqc(1'b0);
    rdc(8'h1d, 8'h01);
    rdc(8'h30, 8'h00);
    chk({7'h0, er}, 8'h01);
    print_verdict();
  end
endmodule
